// ### rtl/bttd_pkg.sv
/*
  Package for the bus trace and trigger debug block: register offsets,
  field positions, reset values, trigger modes and carrier structs.
  Assumes an 8-bit Wishbone register bus and a 16-bit CPU address bus.
*/
package bttd_pkg;

  // Register byte offsets
  localparam logic [3:0] BTTD_OFS_CMP_A_HI = 4'h0;
  localparam logic [3:0] BTTD_OFS_CMP_A_LO = 4'h1;
  localparam logic [3:0] BTTD_OFS_CMP_B_HI = 4'h2;
  localparam logic [3:0] BTTD_OFS_CMP_B_LO = 4'h3;
  localparam logic [3:0] BTTD_OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] BTTD_OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] BTTD_OFS_CTRL = 4'h6;
  localparam logic [3:0] BTTD_OFS_TRIG = 4'h7;
  localparam logic [3:0] BTTD_OFS_STAT = 4'h8;

  // Control register fields
  localparam int BTTD_C_EN = 7;
  localparam int BTTD_C_ARM = 6;
  localparam int BTTD_C_TAG = 5;
  localparam int BTTD_C_BRK = 4;
  localparam int BTTD_C_RWA = 3;
  localparam int BTTD_C_CMP_A_DIR_QUALIFY = 2;
  localparam int BTTD_C_RWB = 1;
  localparam int BTTD_C_CMP_B_DIR_QUALIFY = 0;

  // Trigger register fields
  localparam int BTTD_T_SEL = 7;
  localparam int BTTD_T_BEGIN = 6;
  localparam logic [7:0] BTTD_T_WMASK = 8'hCF;

  // Reset values and sizes
  localparam logic [7:0] BTTD_RST_BYTE = 8'h00;
  localparam logic [15:0] BTTD_RST_WORD = 16'h0000;
  localparam int BTTD_DEPTH = 8;
  localparam logic [3:0] BTTD_FULL_CNT = 4'h8;

  // Trigger modes
  localparam logic [3:0] BTTD_M_A_ONLY = 4'h0;
  localparam logic [3:0] BTTD_M_A_OR_B = 4'h1;
  localparam logic [3:0] BTTD_M_A_THEN_B = 4'h2;
  localparam logic [3:0] BTTD_M_EVT_B = 4'h3;
  localparam logic [3:0] BTTD_M_A_THEN_EVT_B = 4'h4;
  localparam logic [3:0] BTTD_M_A_AND_B = 4'h5;
  localparam logic [3:0] BTTD_M_A_NOT_B = 4'h6;
  localparam logic [3:0] BTTD_M_INSIDE = 4'h7;
  localparam logic [3:0] BTTD_M_OUTSIDE = 4'h8;

  // CPU bus observation carrier
  typedef struct packed {
    logic valid;
    logic read;
    logic opfetch;
    logic [15:0] addr;
    logic [7:0] data;
  } bttd_cpu_t;

  // Break request carrier
  typedef struct packed {
    logic tag;
    logic force_brk;
  } bttd_brk_t;

endpackage

// ### rtl/bttd_top.sv
/*
  Bus trace and trigger debug block: two 16-bit comparators, nine trigger
  modes, an eight-word trace FIFO, CPU break requests and PC profiling.
  Assumes a classic Wishbone master with 8-bit data, and CPU bus signals
  synchronous to clk_i. Opcode execution is reported by the CPU core.
*/
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Contract
// [RULE1] Comparator bytes reset zero, locked while armed
// [RULE2] FIFO high byte read-only, zero in event modes
// [RULE3] FIFO high read keeps read position
// [RULE4] FIFO low read advances after returning
// [RULE5] Event modes store bytes in low half
// [RULE6] Armed low reads do not advance FIFO
// [RULE7] Unarmed low read stores last opcode address
// [RULE8] Profiled value emerges eight reads later
// [RULE9] Control always accessible; enable refused when secure
// [RULE10] Arm write sets flag; run end clears
// [RULE11] Bit five picks tag or force
// [RULE12] Break at trigger or full, per trace
// [RULE13] Comparator A direction qualification bits three, two
// [RULE14] Comparator B direction qualification bits one, zero
// [RULE15] Trigger register locked while armed; bits 4,5 zero
// [RULE16] Trigger type qualifies matches with execution
// [RULE17] Bit six picks begin or end trace
// [RULE18] Modes zero to six; nine up none
// [RULE19] Seven inside range, eight outside range
// [RULE20] Armed flag mirrors arm, clears at end; here it is set only when arm is written together with enable
// [RULE21] Valid count cleared at start, no decrement
// [RULE22] Match flags cleared at start, set on match
// [RULE23] Eight 16-bit entries, 16-bit comparators
// [RULE24] Byte registers, one advance per read cycle
module bttd_top (
  input wire logic clk_i, // Bus clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_adr_i, // Register byte address
  input wire logic wb_sel_i, // Byte select
  input wire logic [7:0] wb_dat_i, // Write data
  output logic [7:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic secure_i, // Device is secured
  input wire bttd_pkg::bttd_cpu_t cpu_i, // Observed CPU access
  input wire logic op_exec_i, // Opcode at last fetch executes
  output bttd_pkg::bttd_brk_t brk_o // Break request to CPU
);
  import bttd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [7:0] ctrl_r;
  logic [7:0] trig_r;
  logic armed_status_flag_r;
  logic match_a_flag_r;
  logic match_b_flag_r;
  logic [3:0] fifo_valid_count_r;
  logic [15:0] fifo_r [BTTD_DEPTH];
  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic a_seen_r;
  logic started_r;
  logic [15:0] last_op_r;
  logic [15:0] pend_addr_r;
  logic pend_a_r;
  logic pend_b_r;
  logic ack_r;
  logic [7:0] dat_r;
  bttd_brk_t brk_r;

  // Direction-qualified address match
  function automatic logic dir_ok(input logic qual, input logic val, input logic rd);
    dir_ok = !qual || (val == rd);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  logic req;
  logic wr_req;
  logic rd_req;
  logic armed;
  logic event_mode;
  logic begin_trace;
  // A held strobe is not taken again while its ack stands,
  // so each bus cycle makes at most one register side effect
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_req = req && wb_we_i && wb_sel_i;
  assign rd_req = req && !wb_we_i;
  assign armed = ctrl_r[BTTD_C_ARM];
  assign event_mode = (trig_r[3:0] == BTTD_M_EVT_B) || (trig_r[3:0] == BTTD_M_A_THEN_EVT_B);
  // [RULE17] Event modes force begin
  assign begin_trace = trig_r[BTTD_T_BEGIN] || event_mode;

  ////////////////////////////////////////////////////////////////////////
  // Comparators and trigger mode decode
  logic hit_a;
  logic hit_b;
  logic in_range;
  logic m_a;
  logic m_b;
  logic trig_now;
  logic store_now;
  logic [15:0] store_word;
  logic exec_a;
  logic exec_b;
  // [RULE23] 16-bit compare
  assign in_range = (cpu_i.addr >= cmp_a_r) && (cpu_i.addr <= cmp_b_r);
  // [RULE13] Comparator A direction
  assign hit_a = cpu_i.valid && (cpu_i.addr == cmp_a_r) &&
                 dir_ok(ctrl_r[BTTD_C_CMP_A_DIR_QUALIFY], ctrl_r[BTTD_C_RWA], cpu_i.read);
  // [RULE14] Comparator B direction
  assign hit_b = cpu_i.valid && (cpu_i.addr == cmp_b_r) &&
                 dir_ok(ctrl_r[BTTD_C_CMP_B_DIR_QUALIFY], ctrl_r[BTTD_C_RWB], cpu_i.read);
  // [RULE16] Tag type waits for execution
  assign exec_a = pend_a_r && op_exec_i;
  assign exec_b = pend_b_r && op_exec_i;
  assign m_a = trig_r[BTTD_T_SEL] ? exec_a : hit_a;
  assign m_b = trig_r[BTTD_T_SEL] ? exec_b : hit_b;

  // Trigger event and event-only storage
  always_comb begin
    trig_now = 1'b0;
    store_now = 1'b0;
    store_word = cpu_i.addr;
    case (trig_r[3:0])
      // [RULE18] Mode decode
      BTTD_M_A_ONLY: trig_now = m_a;
      BTTD_M_A_OR_B: trig_now = m_a || m_b;
      BTTD_M_A_THEN_B: trig_now = a_seen_r && m_b;
      BTTD_M_EVT_B: begin
        trig_now = hit_b;
        store_now = hit_b;
        // [RULE5] Byte in low half
        store_word = {BTTD_RST_BYTE, cpu_i.data};
      end
      BTTD_M_A_THEN_EVT_B: begin
        trig_now = m_a || a_seen_r;
        store_now = a_seen_r && hit_b;
        store_word = {BTTD_RST_BYTE, cpu_i.data};
      end
      BTTD_M_A_AND_B: trig_now = hit_a && (cpu_i.data == cmp_b_r[7:0]);
      BTTD_M_A_NOT_B: trig_now = hit_a && (cpu_i.data != cmp_b_r[7:0]);
      // [RULE19] Range modes
      BTTD_M_INSIDE: trig_now = cpu_i.valid && in_range;
      BTTD_M_OUTSIDE: trig_now = cpu_i.valid && (cpu_i.addr < cmp_a_r || cpu_i.addr > cmp_b_r);
      default: trig_now = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Run sequencing
  logic run_on;
  logic capture;
  logic end_hit;
  logic full_hit;
  logic arm_wr;
  logic stop_wr;
  assign run_on = armed && ctrl_r[BTTD_C_EN];
  // Event modes store the triggering byte as well, so eight B hits fill the FIFO;
  // address modes store only real opcode fetches, never idle bus cycles.
  // An end trace stores every fetch, a begin trace only from its trigger on.
  assign capture = run_on && (event_mode ? ((started_r || trig_now) && store_now) :
                   (cpu_i.valid && cpu_i.opfetch && (started_r || trig_now || !begin_trace)));
  assign end_hit = run_on && !begin_trace && trig_now;
  // Last free slot taken: the run ends on this capture
  assign full_hit = run_on && begin_trace && capture && (fifo_valid_count_r == BTTD_FULL_CNT - 4'h1);
  // A secured part refuses the arm write outright, so no run state is cleared
  assign arm_wr = wr_req && (wb_adr_i == BTTD_OFS_CTRL) && wb_dat_i[BTTD_C_ARM] && wb_dat_i[BTTD_C_EN] &&
                  !secure_i;
  // Any other control write stops a run
  assign stop_wr = wr_req && (wb_adr_i == BTTD_OFS_CTRL) && !arm_wr;

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= BTTD_RST_BYTE;
    end else if (wr_req && wb_adr_i == BTTD_OFS_CTRL) begin
      ctrl_r <= wb_dat_i;
      // [RULE9] Enable refused when secure
      if (secure_i) begin
        ctrl_r[BTTD_C_EN] <= 1'b0;
        ctrl_r[BTTD_C_ARM] <= 1'b0;
      end
    end else if (end_hit || full_hit) begin
      // [RULE10] Run end clears arm
      ctrl_r[BTTD_C_ARM] <= 1'b0;
    end
  end

  // Armed flag
  // Set only by an accepted arm write; cleared by any stop or run end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_status_flag_r <= 1'b0;
    end else if (arm_wr && !secure_i) begin
      // [RULE20] Mirror arm
      armed_status_flag_r <= 1'b1;
    end else if (stop_wr || end_hit || full_hit) begin
      armed_status_flag_r <= 1'b0;
    end
  end

  // Comparator and trigger registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_r <= BTTD_RST_WORD;
      cmp_b_r <= BTTD_RST_WORD;
      trig_r <= BTTD_RST_BYTE;
    end else if (wr_req && !armed) begin
      // [RULE1] Locked while armed
      case (wb_adr_i)
        BTTD_OFS_CMP_A_HI: cmp_a_r[15:8] <= wb_dat_i;
        BTTD_OFS_CMP_A_LO: cmp_a_r[7:0] <= wb_dat_i;
        BTTD_OFS_CMP_B_HI: cmp_b_r[15:8] <= wb_dat_i;
        BTTD_OFS_CMP_B_LO: cmp_b_r[7:0] <= wb_dat_i;
        // [RULE15] Bits 4,5 held zero
        BTTD_OFS_TRIG: trig_r <= wb_dat_i & BTTD_T_WMASK;
        default: ;
      endcase
    end
  end

  // Sequence state, match flags and tag tracking
  // A tag-type match waits here for the fetched opcode to execute
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_seen_r <= 1'b0;
      started_r <= 1'b0;
      match_a_flag_r <= 1'b0;
      match_b_flag_r <= 1'b0;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      pend_addr_r <= BTTD_RST_WORD;
    end else if (arm_wr) begin
      // [RULE22] Cleared at run start
      a_seen_r <= 1'b0;
      started_r <= 1'b0;
      match_a_flag_r <= 1'b0;
      match_b_flag_r <= 1'b0;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
    end else if (run_on) begin
      if (m_a) begin
        match_a_flag_r <= 1'b1;
        a_seen_r <= 1'b1;
      end
      if (m_b) begin
        match_b_flag_r <= 1'b1;
      end
      if (begin_trace && trig_now) begin
        started_r <= 1'b1;
      end
      if (cpu_i.valid && cpu_i.opfetch) begin
        pend_a_r <= hit_a;
        pend_b_r <= hit_b;
        pend_addr_r <= cpu_i.addr;
      end else if (op_exec_i) begin
        pend_a_r <= 1'b0;
        pend_b_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trace FIFO
  logic lo_read;
  logic hi_read;
  assign lo_read = rd_req && (wb_adr_i == BTTD_OFS_FIFO_LO);
  assign hi_read = rd_req && (wb_adr_i == BTTD_OFS_FIFO_HI);

  // Last fetched opcode address
  // Tracked always, so profiling works while no run is active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_op_r <= BTTD_RST_WORD;
    end else if (cpu_i.valid && cpu_i.opfetch) begin
      last_op_r <= cpu_i.addr;
    end
  end

  // FIFO storage, pointers and count
  // A capture and a low read never meet: reads only move the pointer when
  // unarmed, and captures only happen while armed. The read data was muxed
  // from the old slot, so the slot just read takes the profiled address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < BTTD_DEPTH; i++) begin
        fifo_r[i] <= BTTD_RST_WORD;
      end
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      fifo_valid_count_r <= 4'h0;
    end else if (arm_wr) begin
      // [RULE21] Count cleared at start
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      fifo_valid_count_r <= 4'h0;
    end else if (capture) begin
      fifo_r[wr_ptr_r] <= store_word;
      wr_ptr_r <= wr_ptr_r + 3'h1;
      rd_ptr_r <= wr_ptr_r + 3'h1;
      if (fifo_valid_count_r != BTTD_FULL_CNT) begin
        fifo_valid_count_r <= fifo_valid_count_r + 4'h1;
      end
    end else if (lo_read && !armed) begin
      // [RULE4] Advance after low read
      // [RULE6] No advance while armed
      // [RULE24] Once per read cycle
      rd_ptr_r <= rd_ptr_r + 3'h1;
      // [RULE7] Profile into last location
      // [RULE8] Emerges eight reads on
      fifo_r[rd_ptr_r] <= last_op_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Break requests
  // Pulses one cycle after the run ends; the arm bit is already clear then,
  // so a single end event cannot repeat the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_r <= '0;
    end else begin
      // [RULE12] Break at end trigger or full
      // [RULE11] Tag or force select
      brk_r.tag <= ctrl_r[BTTD_C_BRK] && ctrl_r[BTTD_C_TAG] && (end_hit || full_hit);
      brk_r.force_brk <= ctrl_r[BTTD_C_BRK] && !ctrl_r[BTTD_C_TAG] && (end_hit || full_hit);
    end
  end
  assign brk_o = brk_r;

  ////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge
  // Status packs both match flags, the armed flag and the valid count
  logic [7:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      BTTD_OFS_CMP_A_HI: rd_mux = cmp_a_r[15:8];
      BTTD_OFS_CMP_A_LO: rd_mux = cmp_a_r[7:0];
      BTTD_OFS_CMP_B_HI: rd_mux = cmp_b_r[15:8];
      BTTD_OFS_CMP_B_LO: rd_mux = cmp_b_r[7:0];
      // [RULE2] Zero in event modes
      // [RULE3] High read no advance
      BTTD_OFS_FIFO_HI: rd_mux = event_mode ? BTTD_RST_BYTE : fifo_r[rd_ptr_r][15:8];
      BTTD_OFS_FIFO_LO: rd_mux = fifo_r[rd_ptr_r][7:0];
      BTTD_OFS_CTRL: rd_mux = ctrl_r;
      BTTD_OFS_TRIG: rd_mux = trig_r;
      BTTD_OFS_STAT: rd_mux = {match_a_flag_r, match_b_flag_r, armed_status_flag_r, 1'b0, fifo_valid_count_r};
      default: rd_mux = BTTD_RST_BYTE;
    endcase
  end

  // One-cycle acknowledge with registered data
  // Every access answers one edge after it is taken, even a refused write,
  // and a write answers with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= BTTD_RST_BYTE;
    end else begin
      ack_r <= req;
      dat_r <= rd_req ? rd_mux : BTTD_RST_BYTE;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Unused parity of the whole pending opcode fetch address
  logic unused_ok;
  assign unused_ok = ^pend_addr_r;

endmodule // bttd_top

// ### verif/bttd_cpu_model.sv
/*
  CPU bus model: drives one observed access per call, then idles.
  Assumes the caller is the bench, at a rising clock edge.
*/
`timescale 1ns/1ps
module bttd_cpu_model
  import bttd_pkg::*;
(
  input wire logic clk_i, // Bus clock
  output bttd_pkg::bttd_cpu_t cpu_o, // Observed access
  output logic op_exec_o // Fetched opcode executes
);
  // Idle at start
  initial begin
    cpu_o = '0;
    op_exec_o = 1'b0;
  end
  // One access, then scrambled idle fields; reads are opcode fetches
  task automatic access(input logic [15:0] a, input logic r, input logic [7:0] d);
    @(posedge clk_i);
    cpu_o <= '{valid: 1'b1, read: r, opfetch: r, addr: a, data: d};
    @(posedge clk_i);
    cpu_o <= '{valid: 1'b0, read: ~r, opfetch: 1'b0, addr: ~a, data: ~d};
    op_exec_o <= r;
    @(posedge clk_i);
    op_exec_o <= 1'b0;
  endtask
endmodule // bttd_cpu_model

// ### verif/bttd_top_bench.sv
/*
  Self-checking bench for bttd_top: Wishbone register tasks, trigger runs,
  event capture and profiling reads. Assumes the CPU model and checker.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module bttd_top_bench;
  import bttd_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sel = 0, secure = 0, ack, op_exec;
  logic [3:0] adr = 0;
  logic [7:0] wdat = 0, q, dat_o;
  int tag_cnt = 0, force_cnt = 0, t0 = 0, f0 = 0;
  int bad_count = 0, tests_run = 0, cycles = 0;
  bttd_cpu_t cpu_bus;
  bttd_brk_t brk;
  always #20 clk_i = ~clk_i;
  bttd_top u_bttd_top(.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .secure_i(secure),
    .cpu_i(cpu_bus), .op_exec_i(op_exec), .brk_o(brk));
  bttd_cpu_model u_bttd_cpu_model(.clk_i, .cpu_o(cpu_bus), .op_exec_o(op_exec));
  // Timeout and break pulse counts
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (brk.tag === 1'b1) tag_cnt <= tag_cnt + 1;
    if (brk.force_brk === 1'b1) force_cnt <= force_cnt + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Break kinds seen since the last mark
  function automatic logic [1:0] brks();
    brks = {tag_cnt != t0, force_cnt != f0};
  endfunction
  // Classic single Wishbone cycle, held until ack
  task xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, sel, we, adr, wdat} <= {3'b111, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task cpu(input logic [15:0] a, input logic r, input logic [7:0] d);
    u_bttd_cpu_model.access(a, r, d);
    repeat (4) @(posedge clk_i);
  endtask
  // Armed run: first access must not break, second gives break kind e
  task run(input logic [7:0] t, input logic [7:0] c, input logic [15:0] a1, input logic r1,
    input logic [15:0] a2, input logic r2, input logic [1:0] e);
    xfer(BTTD_OFS_TRIG, 1, t);
    xfer(BTTD_OFS_CTRL, 1, c | 8'hD0);
    t0 = tag_cnt;
    f0 = force_cnt;
    cpu(a1, r1, 8'h00);
    `CHK(brks(), 2'b00)
    cpu(a2, r2, 8'hF0);
    `CHK(brks(), e)
    xfer(BTTD_OFS_CTRL, 1, 8'h00);
    xfer(BTTD_OFS_STAT, 0, 8'h00);
    `CHK(q[5], 1'b0)
    $display("run trig %h ctrl %h done", t, c);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) if (i != 4 && i != 5) begin
      xfer(4'(i), 0, 8'h00);
      `CHK(q, 8'h00)
    end
    secure <= 1'b1;
    xfer(BTTD_OFS_CTRL, 1, 8'hC0);
    xfer(BTTD_OFS_CTRL, 0, 8'h00);
    `CHK(q, 8'h00)
    secure <= 1'b0;
    xfer(BTTD_OFS_TRIG, 1, 8'hFF);
    xfer(BTTD_OFS_TRIG, 0, 8'h00);
    `CHK(q, 8'hCF)
    $display("reset and access test done");
    xfer(BTTD_OFS_CMP_A_HI, 1, 8'h10);
    xfer(BTTD_OFS_CMP_A_LO, 1, 8'h34);
    xfer(BTTD_OFS_CMP_B_HI, 1, 8'h10);
    xfer(BTTD_OFS_CMP_B_LO, 1, 8'hF0);
    xfer(BTTD_OFS_TRIG, 1, 8'h00);
    xfer(BTTD_OFS_CTRL, 1, 8'hC0);
    xfer(BTTD_OFS_STAT, 0, 8'h00);
    `CHK(q, 8'h20)
    xfer(BTTD_OFS_CMP_A_LO, 1, 8'hFF);
    xfer(BTTD_OFS_CMP_A_LO, 0, 8'h00);
    `CHK(q, 8'h34)
    xfer(BTTD_OFS_TRIG, 1, 8'h08);
    xfer(BTTD_OFS_TRIG, 0, 8'h00);
    `CHK(q, 8'h00)
    for (int i = 0; i < 10; i++) cpu(16'(16'h1000 + i), 1, 8'h00);
    cpu(16'h1034, 1, 8'h00);
    xfer(BTTD_OFS_STAT, 0, 8'h00);
    `CHK(q, 8'h88)
    `CHK(brks(), 2'b00)
    $display("end trace test done");
    run(8'h00, 8'h00, 16'h1033, 1, 16'h1034, 1, 2'b01);
    run(8'h01, 8'h20, 16'h1035, 1, 16'h10F0, 1, 2'b10);
    run(8'h07, 8'h00, 16'h1033, 1, 16'h10F0, 1, 2'b01);
    run(8'h08, 8'h00, 16'h1034, 1, 16'h10F1, 1, 2'b01);
    run(8'h09, 8'h00, 16'h1035, 1, 16'h1034, 1, 2'b00);
    run(8'h00, 8'h0C, 16'h1034, 0, 16'h1034, 1, 2'b01);
    run(8'h01, 8'h01, 16'h10F0, 1, 16'h10F0, 0, 2'b01);
    run(8'h02, 8'h00, 16'h1034, 1, 16'h10F0, 1, 2'b01);
    run(8'h05, 8'h00, 16'h1034, 1, 16'h1034, 1, 2'b01);
    run(8'h06, 8'h00, 16'h1035, 1, 16'h1034, 1, 2'b00);
    run(8'h80, 8'h00, 16'h1034, 0, 16'h1034, 1, 2'b01);
    run(8'h40, 8'h00, 16'h1033, 1, 16'h1034, 1, 2'b00);
    xfer(BTTD_OFS_TRIG, 1, 8'h03);
    xfer(BTTD_OFS_CTRL, 1, 8'hD0);
    t0 = tag_cnt;
    f0 = force_cnt;
    for (int i = 0; i < 8; i++) cpu(16'h10F0, 0, 8'(8'hA0 + i));
    xfer(BTTD_OFS_STAT, 0, 8'h00);
    `CHK(q, 8'h48)
    `CHK(brks(), 2'b01)
    for (int i = 0; i < 8; i++) begin
      cpu(16'(16'h2000 + i), 1, 8'h00);
      xfer(BTTD_OFS_FIFO_HI, 0, 8'h00);
      `CHK(q, 8'h00)
      xfer(BTTD_OFS_FIFO_LO, 0, 8'h00);
      `CHK(q, 8'(8'hA0 + i))
    end
    $display("event capture test done");
    xfer(BTTD_OFS_TRIG, 1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cpu(16'(16'h2100 + i), 1, 8'h00);
      xfer(BTTD_OFS_FIFO_HI, 0, 8'h00);
      `CHK(q, 8'h20)
      xfer(BTTD_OFS_FIFO_HI, 0, 8'h00);
      `CHK(q, 8'h20)
      xfer(BTTD_OFS_FIFO_LO, 0, 8'h00);
      `CHK(q, 8'(i))
    end
    $display("profiling test done");
    final_report();
  end
endmodule // bttd_top_bench
bind bttd_top bttd_top_monitor u_bttd_top_monitor(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .brk_o);

// ### verif/bttd_top_monitor.sv
/*
  Checker for the bus trace and trigger debug block port timing.
  Assumes it is bound to bttd_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module bttd_top_monitor
  import bttd_pkg::*;
(
  input wire logic clk_i, // Bus clock
  input wire logic rst_i, // Sync reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Address
  input wire logic [7:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire bttd_pkg::bttd_brk_t brk_o // Break request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request and read-answer steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !$past(wb_we_i);
  endsequence
  // Bus answer timing and data
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_wr_zero;
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 8'h00;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer data not zero");
  property p_unmapped;
    s_rd and ($past(wb_adr_i) > 4'h8) |-> wb_dat_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_trig_bits;
    s_rd and ($past(wb_adr_i) == BTTD_OFS_TRIG) |-> wb_dat_o[5:4] == 2'b00;
  endproperty
  a_trig_bits: assert property (p_trig_bits) else $error("trigger bits 5:4 not zero");
  // Break request shape
  property p_brk_excl;
    !(brk_o.tag && brk_o.force_brk);
  endproperty
  a_brk_excl: assert property (p_brk_excl) else $error("tag and force together");
  property p_brk_pulse;
    (brk_o != 2'b00) |=> (brk_o == 2'b00);
  endproperty
  a_brk_pulse: assert property (p_brk_pulse) else $error("break longer than one cycle");
endmodule // bttd_top_monitor
